/* pkg/crm_pkg.sv */
`default_nettype none

package crm_pkg;

	localparam int CRM_OFS_W  = 7;
	localparam int CRM_BANK_W = 5;
	localparam int CRM_PTR_W  = 16;
	localparam int CRM_PCH_W  = 7;

	// Printed locations of the core group in bank 15; only the low seven bits decode.
	localparam logic [11:0] CRM_ADDR_IND0  = 12'h780;
	localparam logic [11:0] CRM_ADDR_IND1  = 12'h781;
	localparam logic [11:0] CRM_ADDR_PCL   = 12'h782;
	localparam logic [11:0] CRM_ADDR_STAT  = 12'h783;
	localparam logic [11:0] CRM_ADDR_P0LO  = 12'h784;
	localparam logic [11:0] CRM_ADDR_P0HI  = 12'h785;
	localparam logic [11:0] CRM_ADDR_P1LO  = 12'h786;
	localparam logic [11:0] CRM_ADDR_P1HI  = 12'h787;
	localparam logic [11:0] CRM_ADDR_BANK  = 12'h788;
	localparam logic [11:0] CRM_ADDR_WORK  = 12'h789;
	localparam logic [11:0] CRM_ADDR_PCH   = 12'h78a;
	localparam logic [11:0] CRM_ADDR_INTC  = 12'h78b;
	localparam logic [6:0]  CRM_PTR_STEP   = 7'h02;

	localparam logic [6:0]  CRM_CORE_LAST    = 7'h0b;
	localparam logic [6:0]  CRM_UNIMPL_FIRST = 7'h0c;
	localparam logic [6:0]  CRM_UNIMPL_LAST  = 7'h1f;

	localparam logic [7:0]  CRM_RST_BYTE    = 8'h00;
	localparam logic [4:0]  CRM_RST_STAT    = 5'h18;
	localparam logic [4:0]  CRM_RST_BANK    = 5'h00;
	localparam logic [6:0]  CRM_RST_PCH     = 7'h00;
	localparam logic [2:0]  CRM_INT_FLAGS   = 3'h7;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} crm_mem_req_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} crm_arith_t;

	function automatic logic [6:0] crm_ofs(input logic [11:0] a);
		return a[6:0];
	endfunction : crm_ofs

	function automatic logic crm_is_core(input logic [6:0] o);
		return o <= CRM_CORE_LAST;
	endfunction : crm_is_core

	function automatic logic crm_is_unimpl(input logic [6:0] o);
		return (o >= CRM_UNIMPL_FIRST) && (o <= CRM_UNIMPL_LAST);
	endfunction : crm_is_unimpl

endpackage : crm_pkg

`default_nettype wire

/* src/crm_core_bank.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module crm_core_bank (
	input  wire logic                 i_clock,
	input  wire logic                 i_resetn,
	input  wire logic                 i_por,
	input  wire logic                 i_cause_timeout,
	input  wire logic                 i_cause_power_down,
	input  wire logic [6:0]           i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [7:0]           o_rdata,
	output crm_pkg::crm_mem_req_t     o_mem_req,
	input  wire logic [7:0]           i_mem_rdata,
	input  wire logic                 i_arith_we,
	input  wire crm_pkg::crm_arith_t  i_arith,
	input  wire logic                 i_pc_low_we,
	input  wire logic [7:0]           i_pc_low,
	input  wire logic [2:0]           i_int_events,
	output logic                      o_pc_jump,
	output logic      [14:0]          o_pc_target,
	output logic      [7:0]           o_pc_low,
	output logic      [4:0]           o_bank,
	output logic      [7:0]           o_working,
	output logic      [7:0]           o_interrupt_control,
	output logic      [7:0]           o_status
);

	logic [7:0]  pc_low_r;
	logic [6:0]  pch_r;
	logic [4:0]  bank_r;
	logic [7:0]  working_r;
	logic [7:0]  interrupt_control_r;
	logic [7:0]  interrupt_control_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic        jump_r;
	logic [14:0] target_r;
	logic [15:0] ptr [2];
	logic [1:0]  hit_plo;
	logic [1:0]  hit_phi;

	wire logic        is_core   = crm_pkg::crm_is_core(i_addr);
	wire logic        is_unimpl = crm_pkg::crm_is_unimpl(i_addr);
	wire logic        is_direct = !is_core && !is_unimpl;
	wire logic        hit_ind0  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_IND0);
	wire logic        hit_ind1  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_IND1);
	wire logic        hit_pcl   = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_PCL);
	wire logic        hit_stat  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_STAT);
	wire logic        hit_bank  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_BANK);
	wire logic        hit_work  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_WORK);
	wire logic        hit_pch   = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_PCH);
	wire logic        hit_intc  = i_addr == crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_INTC);
	wire logic        ind_sel   = hit_ind0 || hit_ind1;
	wire logic        goes_out  = ind_sel || is_direct;
	wire logic [15:0] ind_addr  = hit_ind1 ? ptr[1] : ptr[0];
	wire logic [15:0] dir_addr  = {4'h0, bank_r, i_addr};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ptr
			localparam logic [6:0] LO_OFS =
				7'(crm_pkg::crm_ofs(crm_pkg::CRM_ADDR_P0LO) + crm_pkg::CRM_PTR_STEP * g);
			assign hit_plo[g] = i_addr == LO_OFS;
			assign hit_phi[g] = i_addr == 7'(LO_OFS + 7'h01);
			crm_pointer crm_pointer_i (
				.i_clock   (i_clock),
				.i_resetn  (i_resetn),
				.i_por     (i_por),
				.i_wr_low  (i_wr && hit_plo[g]),
				.i_wr_high (i_wr && hit_phi[g]),
				.i_wdata   (i_wdata),
				.o_ptr     (ptr[g])
			);
		end
	endgenerate

	crm_status crm_status_i (
		.i_clock            (i_clock),
		.i_resetn           (i_resetn),
		.i_por              (i_por),
		.i_cause_timeout    (i_cause_timeout),
		.i_cause_power_down (i_cause_power_down),
		.i_sw_we            (i_wr && hit_stat),
		.i_wdata            (i_wdata),
		.i_arith_we         (i_arith_we),
		.i_arith            (i_arith),
		.o_status           (o_status)
	);

	// The indirect ports hold no storage; the access is steered to the pointer's target.
	assign o_mem_req.addr  = ind_sel ? ind_addr : dir_addr;
	assign o_mem_req.wdata = i_wdata;
	assign o_mem_req.wr    = i_wr && goes_out;
	assign o_mem_req.rd    = i_rd && goes_out;

	// Core offsets decode on the offset alone, so the bank never hides them.
	assign rdata_nxt = goes_out          ? i_mem_rdata :
		hit_pcl                      ? pc_low_r :
		hit_stat                     ? o_status :
		hit_plo[0]                   ? ptr[0][7:0] :
		hit_phi[0]                   ? ptr[0][15:8] :
		hit_plo[1]                   ? ptr[1][7:0] :
		hit_phi[1]                   ? ptr[1][15:8] :
		hit_bank                     ? {3'h0, bank_r} :
		hit_work                     ? working_r :
		hit_pch                      ? {1'b0, pch_r} :
		hit_intc                     ? interrupt_control_r : 8'h00;

	// Hardware event flags win over a software write that clears them in the same cycle.
	assign interrupt_control_nxt = ((i_wr && hit_intc) ? i_wdata : interrupt_control_r)
		| {5'h00, i_int_events & crm_pkg::CRM_INT_FLAGS};

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			rdata_r <= crm_pkg::CRM_RST_BYTE;
		end else begin
			rdata_r <= i_rd ? rdata_nxt : crm_pkg::CRM_RST_BYTE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			pc_low_r <= crm_pkg::CRM_RST_BYTE;
		end else if (i_wr && hit_pcl) begin
			pc_low_r <= i_wdata;
		end else if (i_pc_low_we) begin
			pc_low_r <= i_pc_low;
		end
	end

	// A write to the low byte is a computed jump that also takes the buffered upper bits.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			jump_r   <= 1'b0;
			target_r <= {crm_pkg::CRM_RST_PCH, crm_pkg::CRM_RST_BYTE};
		end else begin
			jump_r   <= i_wr && hit_pcl;
			target_r <= (i_wr && hit_pcl) ? {pch_r, i_wdata} : target_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			pch_r <= crm_pkg::CRM_RST_PCH;
		end else if (i_wr && hit_pch) begin
			pch_r <= i_wdata[6:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			bank_r <= crm_pkg::CRM_RST_BANK;
		end else if (i_wr && hit_bank) begin
			bank_r <= i_wdata[4:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			if (i_por) begin
				working_r <= crm_pkg::CRM_RST_BYTE;
			end
		end else if (i_wr && hit_work) begin
			working_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			interrupt_control_r <= crm_pkg::CRM_RST_BYTE;
		end else begin
			interrupt_control_r <= interrupt_control_nxt;
		end
	end

	assign o_rdata     = rdata_r;
	assign o_pc_jump   = jump_r;
	assign o_pc_target = target_r;
	assign o_pc_low    = pc_low_r;
	assign o_bank      = bank_r;
	assign o_working   = working_r;
	assign o_interrupt_control    = interrupt_control_r;

	// Checks below sample one cycle after reset release where they look at reset values.
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	a_indirect_read_redirect: assert property (
		(i_rd && hit_ind1) |-> (o_mem_req.rd && o_mem_req.addr == ptr[1])
			##1 (o_rdata == $past(i_mem_rdata)))
		else $error("indirect read not sent to pointer one");

	a_indirect_write_redirect: assert property (
		(i_wr && hit_ind0) |-> (o_mem_req.wr && o_mem_req.addr == ptr[0]
			&& o_mem_req.wdata == i_wdata))
		else $error("indirect write not sent to pointer zero");

	a_core_bank_free: assert property (
		(i_rd && hit_stat) |-> !o_mem_req.rd ##1 (o_rdata == $past(o_status)))
		else $error("status read depends on bank");

	a_unimpl_reads_zero: assert property (
		(i_rd && is_unimpl) |-> !o_mem_req.rd ##1 (o_rdata == 8'h00))
		else $error("unimplemented location read nonzero");

	a_latch_high_buffer: assert property (
		(i_wr && hit_pch) ##1 (i_rd && hit_pch) |=> (o_rdata == {1'b0, $past(i_wdata[6:0], 2)}))
		else $error("upper counter buffer readback wrong");

	a_status_poweron_value: assert property (
		($rose(i_resetn) && $past(i_por)) |-> (o_status == {3'h0, crm_pkg::CRM_RST_STAT}))
		else $error("status wrong after power-on reset");

	a_warm_reset_keeps: assert property (
		($rose(i_resetn) && !$past(i_por)) |-> (working_r == $past(working_r)
			&& ptr[0][15:8] == 8'h00 && ptr[1][15:8] == 8'h00 && pch_r == 7'h00))
		else $error("warm reset disturbed kept registers");

	a_pointer_byte_write: assert property (
		(i_wr && hit_plo[1]) |=> (ptr[1][7:0] == $past(i_wdata)
			&& ptr[1][15:8] == $past(ptr[1][15:8])))
		else $error("pointer low byte write wrong");

	a_counter_low_reset: assert property (
		$rose(i_resetn) |-> (pc_low_r == 8'h00 && !o_pc_jump && bank_r == 5'h00))
		else $error("counter low byte not cleared by reset");

	a_bank_direct_address: assert property (
		(i_wr && hit_bank) ##1 (i_rd && is_direct) |-> (o_mem_req.rd
			&& o_mem_req.addr[11:7] == $past(i_wdata[4:0])))
		else $error("direct access not banked");

	// Both ports are checked both ways round so a swapped pointer select shows up.
	a_indirect_write_one: assert property (
		(i_wr && hit_ind1) |-> (o_mem_req.wr && o_mem_req.addr == ptr[1]))
		else $error("indirect write not sent to pointer one");

	a_indirect_read_zero: assert property (
		(i_rd && hit_ind0) |-> (o_mem_req.rd && o_mem_req.addr == ptr[0])
			##1 (o_rdata == $past(i_mem_rdata)))
		else $error("indirect read not sent to pointer zero");

	a_indirect_no_storage: assert property (
		(i_wr && ind_sel) |=> ($stable(working_r) && $stable(pch_r) && $stable(bank_r)))
		else $error("indirect write touched a core register");

	// Core offsets stay local whatever the bank select holds.
	a_core_stays_local: assert property (
		(is_core && !ind_sel) |-> (!o_mem_req.rd && !o_mem_req.wr))
		else $error("core offset leaked to data memory");

	a_core_write_any_bank: assert property (
		(i_wr && hit_work && bank_r != 5'h00) |=> (working_r == $past(i_wdata)))
		else $error("working register write lost outside bank zero");

	a_unimpl_write_ignored: assert property (
		(i_wr && is_unimpl) |-> !o_mem_req.wr ##1 ($stable(working_r) && $stable(bank_r)
			&& $stable(pch_r) && $stable(interrupt_control_r)))
		else $error("write to unimplemented offset had an effect");

	a_rdata_idle_zero: assert property (
		!i_rd |=> (o_rdata == 8'h00))
		else $error("read data not zero outside a read");

	a_bank_pad_zero: assert property (
		(i_rd && hit_bank) |=> (o_rdata[7:5] == 3'h0))
		else $error("unused bank select bits read as one");

	a_latch_top_zero: assert property (
		(i_rd && hit_pch) |=> (o_rdata[7] == 1'b0))
		else $error("upper counter buffer top bit read as one");

	a_latch_reset_clear: assert property (
		$rose(i_resetn) |-> (pch_r == 7'h00))
		else $error("upper counter buffer survived reset");

	a_jump_takes_buffer: assert property (
		(i_wr && hit_pcl) |=> (o_pc_jump && o_pc_target == {$past(pch_r), $past(i_wdata)}))
		else $error("computed jump lost the buffered upper bits");

	a_status_cause_load: assert property (
		($rose(i_resetn) && !$past(i_por)) |-> (o_status[4:3]
			== {$past(i_cause_timeout), $past(i_cause_power_down)}))
		else $error("status cause bits wrong after warm reset");

	a_status_soft_write: assert property (
		(i_wr && hit_stat) |=> (o_status[2:0] == $past(i_wdata[2:0])
			&& $stable(o_status[4:3])))
		else $error("status write reached the wrong bits");

	a_status_core_update: assert property (
		(i_arith_we && !(i_wr && hit_stat)) |=> (o_status[2:0] == $past(i_arith)))
		else $error("arithmetic flags not updated");

	a_poweron_clears_kept: assert property (
		($rose(i_resetn) && $past(i_por)) |-> (working_r == 8'h00
			&& ptr[0][7:0] == 8'h00 && ptr[1][7:0] == 8'h00))
		else $error("power-on reset left a kept register set");

	a_pointer_high_write: assert property (
		(i_wr && hit_phi[0]) |=> (ptr[0][15:8] == $past(i_wdata)
			&& ptr[0][7:0] == $past(ptr[0][7:0])))
		else $error("pointer high byte write wrong");

	a_counter_low_write: assert property (
		(i_wr && hit_pcl) |=> (o_pc_low == $past(i_wdata)))
		else $error("counter low byte write lost");

	a_counter_low_core: assert property (
		(i_pc_low_we && !(i_wr && hit_pcl)) |=> (o_pc_low == $past(i_pc_low)))
		else $error("counter low byte not updated by the core");

	a_bank_five_bits: assert property (
		(i_wr && hit_bank) |=> (o_bank == $past(i_wdata[4:0])))
		else $error("bank select write wrong");

	a_direct_address_form: assert property (
		(i_rd && is_direct) |-> (o_mem_req.rd && o_mem_req.addr[6:0] == i_addr
			&& o_mem_req.addr[11:7] == o_bank && o_mem_req.addr[15:12] == 4'h0))
		else $error("direct access address malformed");

	c_indirect_read: cover property ((i_rd && ind_sel) ##1 (o_rdata != 8'h00));
	c_bank_then_direct: cover property ((i_wr && hit_bank) ##1 (i_wr && is_direct));
	c_computed_jump: cover property ((i_wr && hit_pch) ##[1:4] (i_wr && hit_pcl) ##1 o_pc_jump);
	c_event_beats_clear: cover property (i_wr && hit_intc && (i_int_events != 3'h0));
	c_warm_reset: cover property ($rose(i_resetn) && !$past(i_por));

endmodule : crm_core_bank

`default_nettype wire

/* src/crm_pointer.sv */
`timescale 1ns/10ps
`default_nettype none

module crm_pointer (
	input  wire logic        i_clock,
	input  wire logic        i_resetn,
	input  wire logic        i_por,
	input  wire logic        i_wr_low,
	input  wire logic        i_wr_high,
	input  wire logic [7:0]  i_wdata,
	output logic      [15:0] o_ptr
);

	logic [7:0] low_r;
	logic [7:0] high_r;

	// The low byte survives warm resets so a pointer walk can resume; the high byte does not.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			if (i_por) begin
				low_r <= crm_pkg::CRM_RST_BYTE;
			end
		end else if (i_wr_low) begin
			low_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			high_r <= crm_pkg::CRM_RST_BYTE;
		end else if (i_wr_high) begin
			high_r <= i_wdata;
		end
	end

	assign o_ptr = {high_r, low_r};

endmodule : crm_pointer

`default_nettype wire

/* src/crm_status.sv */
`timescale 1ns/10ps
`default_nettype none

module crm_status (
	input  wire logic               i_clock,
	input  wire logic               i_resetn,
	input  wire logic               i_por,
	input  wire logic               i_cause_timeout,
	input  wire logic               i_cause_power_down,
	input  wire logic               i_sw_we,
	input  wire logic [7:0]         i_wdata,
	input  wire logic               i_arith_we,
	input  wire crm_pkg::crm_arith_t i_arith,
	output logic      [7:0]         o_status
);

	logic               timeout_flag_r;
	logic               power_down_flag_r;
	crm_pkg::crm_arith_t arith_r;

	// The two cause flags are read-only to software and only move at reset.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			if (i_por) begin
				{timeout_flag_r, power_down_flag_r, arith_r} <= crm_pkg::CRM_RST_STAT;
			end else begin
				timeout_flag_r    <= i_cause_timeout;
				power_down_flag_r <= i_cause_power_down;
			end
		end else if (i_sw_we) begin
			arith_r <= i_wdata[2:0];
		end else if (i_arith_we) begin
			arith_r <= i_arith;
		end
	end

	assign o_status = {3'h0, timeout_flag_r, power_down_flag_r, arith_r};

endmodule : crm_status

`default_nettype wire

/* testbench/crm_core_bank_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module crm_core_bank_tb;
	logic                  i_clock;
	logic                  i_resetn;
	logic                  i_por;
	logic                  i_cause_timeout;
	logic                  i_cause_power_down;
	logic [6:0]            i_addr;
	logic [7:0]            i_wdata;
	logic                  i_wr;
	logic                  i_rd;
	logic [7:0]            o_rdata;
	crm_pkg::crm_mem_req_t o_mem_req;
	logic [7:0]            i_mem_rdata;
	logic                  i_arith_we;
	crm_pkg::crm_arith_t   i_arith;
	logic                  i_pc_low_we;
	logic [7:0]            i_pc_low;
	logic [2:0]            i_int_events;
	logic                  o_pc_jump;
	logic [14:0]           o_pc_target;
	logic [7:0]            o_pc_low;
	logic [4:0]            o_bank;
	logic [7:0]            o_working;
	logic [7:0]            o_interrupt_control;
	logic [7:0]            o_status;
	logic [31:0]           seed;
	logic [15:0]           p0;
	logic [15:0]           p1;
	logic [4:0]            bk;
	logic [7:0]            d;
	logic [7:0]            e;
	logic [6:0]            a;
	logic                  rd_q;
	logic [15:0]           qd[$];
	logic [15:0]           qa[$];
	logic [15:0]           qj[$];
	logic [15:0]           qw[$];
	logic [6:0]            ra_q;
	logic [15:0]           ex;
	int                    n_mismatch;
	int                    num_checks;

	crm_core_bank crm_core_bank_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_por(i_por),
		.i_cause_timeout(i_cause_timeout), .i_cause_power_down(i_cause_power_down),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_mem_req(o_mem_req), .i_mem_rdata(i_mem_rdata), .i_arith_we(i_arith_we),
		.i_arith(i_arith), .i_pc_low_we(i_pc_low_we), .i_pc_low(i_pc_low),
		.i_int_events(i_int_events), .o_pc_jump(o_pc_jump), .o_pc_target(o_pc_target),
		.o_pc_low(o_pc_low), .o_bank(o_bank), .o_working(o_working), .o_interrupt_control(o_interrupt_control),
		.o_status(o_status));

	// Memory answers with a value tied to the address, so a wrong pointer shows in the data.
	function automatic logic [7:0] mf(input logic [15:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5a;
	endfunction : mf
	assign i_mem_rdata = mf(o_mem_req.addr);

	function logic [15:0] ea(input logic [6:0] x);
		return (x == 7'h00) ? p0 : (x == 7'h01) ? p1 : {4'h0, bk, x};
	endfunction : ea

	function logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task end_sim();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task wr(input logic [6:0] x, input logic [7:0] v);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= x;
		i_wdata <= v;
		if (x <= 7'h01 || x >= 7'h20) begin
			qa.push_back(ea(x));
			qw.push_back({8'h00, v});
		end
		case (x)
			7'h04: p0[7:0] = v;
			7'h05: p0[15:8] = v;
			7'h06: p1[7:0] = v;
			7'h07: p1[15:8] = v;
			7'h08: bk = v[4:0];
			default: ;
		endcase
	endtask : wr

	task rd(input logic [6:0] x, input logic [7:0] v);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		i_addr <= x;
		qd.push_back({8'h00, v});
		if (x <= 7'h01 || x >= 7'h20) qa.push_back(ea(x));
	endtask : rd

	task idle();
		@(posedge i_clock);
		i_rd <= 1'b0;
		i_wr <= 1'b0;
	endtask : idle

	task rst(input logic por, input logic to, input logic pd);
		@(posedge i_clock);
		i_resetn <= 1'b0;
		i_por <= por;
		i_cause_timeout <= to;
		i_cause_power_down <= pd;
		i_rd <= 1'b0;
		i_wr <= 1'b0;
		repeat (16) @(posedge i_clock);
		i_resetn <= 1'b1;
		p0[15:8] = 8'h00;
		p1[15:8] = 8'h00;
		bk = 5'h00;
		if (por) begin
			p0[7:0] = 8'h00;
			p1[7:0] = 8'h00;
		end
	endtask : rst

	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		rd_q <= i_rd;
		ra_q <= i_addr;
	end

	// Results are compared mid-cycle, once registered and combinational outputs have settled.
	always @(negedge i_clock) begin
		if (rd_q) begin
			ex = (qd.size() != 0) ? qd.pop_front() : 16'hffff;
			chk({8'h00, o_rdata}, ex);
			// A register read also checks the matching output port against the same note.
			case (ra_q)
				7'h02: chk({8'h00, o_pc_low}, ex);
				7'h03: chk({8'h00, o_status}, ex);
				7'h08: chk({11'h000, o_bank}, ex);
				7'h09: chk({8'h00, o_working}, ex);
				7'h0b: chk({8'h00, o_interrupt_control}, ex);
				default: ;
			endcase
		end
		if (i_resetn && (o_mem_req.rd || o_mem_req.wr))
			chk(o_mem_req.addr, (qa.size() != 0) ? qa.pop_front() : 16'hffff);
		if (i_resetn && o_mem_req.wr)
			chk({8'h00, o_mem_req.wdata}, (qw.size() != 0) ? qw.pop_front() : 16'hffff);
		if (i_resetn && o_pc_jump)
			chk({1'b0, o_pc_target}, (qj.size() != 0) ? qj.pop_front() : 16'hffff);
	end

	initial begin
		repeat (3000) @(posedge i_clock);
		n_mismatch++;
		end_sim();
	end

	initial begin
		{i_resetn, i_por, i_cause_timeout, i_cause_power_down, i_wr, i_rd} = 6'h00;
		{i_addr, i_wdata, i_arith_we, i_arith, i_pc_low_we, i_pc_low, i_int_events} = '0;
		{rd_q, ra_q, p0, p1, bk, n_mismatch, num_checks} = '0;
		seed = 32'h980c;
		rst(1'b1, 1'b1, 1'b1);
		rd(7'h02, 8'h00);
		rd(7'h03, 8'h18);
		for (int i = 4; i < 12; i++) rd(i[6:0], 8'h00);
		for (int i = 12; i < 32; i++) begin
			wr(i[6:0], rnd());
			rd(i[6:0], 8'h00);
		end
		d = rnd();
		wr(7'h03, d);
		rd(7'h03, {5'h03, d[2:0]});
		d = rnd();
		wr(7'h0a, d);
		rd(7'h0a, {1'b0, d[6:0]});
		d = rnd();
		wr(7'h08, d);
		rd(7'h08, {3'h0, d[4:0]});
		wr(7'h0b, 8'h00);
		for (int b = 0; b < 32; b += 5) begin
			wr(7'h09, ~b[7:0]);
			wr(7'h08, b[7:0]);
			e = rnd();
			a = 7'h20 + {1'b0, e[5:0]};
			rd(a, mf(ea(a)));
			rd(7'h09, ~b[7:0]);
			wr(7'h7f, e);
		end
		repeat (4) begin
			wr(7'h04, rnd());
			wr(7'h05, rnd());
			wr(7'h06, rnd());
			wr(7'h07, rnd());
			rd(7'h00, mf(p0));
			rd(7'h01, mf(p1));
			wr(7'h00, rnd());
			wr(7'h01, rnd());
			rd(7'h05, p0[15:8]);
		end
		wr(7'h06, rnd());
		rd(7'h01, mf(p1));
		d = rnd();
		e = rnd();
		wr(7'h0a, d);
		wr(7'h02, e);
		qj.push_back({1'b0, d[6:0], e});
		rd(7'h02, e);
		idle();
		@(posedge i_clock);
		i_arith_we <= 1'b1;
		i_arith <= '{z: 1'b1, dc: 1'b0, c: 1'b1};
		i_pc_low_we <= 1'b1;
		i_pc_low <= 8'h3c;
		i_int_events <= 3'h2;
		// The write clears flag bit 1 in the same cycle as the event sets it; the event must win.
		i_wr <= 1'b1;
		i_addr <= 7'h0b;
		i_wdata <= 8'h40;
		@(posedge i_clock);
		i_wr <= 1'b0;
		i_arith_we <= 1'b0;
		i_pc_low_we <= 1'b0;
		i_int_events <= 3'h0;
		rd(7'h03, 8'h1d);
		rd(7'h02, 8'h3c);
		rd(7'h0b, 8'h42);
		d = rnd();
		wr(7'h09, d);
		rst(1'b0, 1'b0, 1'b1);
		rd(7'h09, d);
		rd(7'h04, p0[7:0]);
		rd(7'h06, p1[7:0]);
		rd(7'h05, 8'h00);
		rd(7'h07, 8'h00);
		rd(7'h03, 8'h0d);
		rd(7'h0a, 8'h00);
		rd(7'h02, 8'h00);
		rd(7'h08, 8'h00);
		rd(7'h0b, 8'h00);
		repeat (3) idle();
		chk(16'(qd.size() + qa.size() + qj.size() + qw.size()), 16'h0000);
		end_sim();
	end
endmodule : crm_core_bank_tb

`default_nettype wire
